// ===== bench/iefb_core_model.sv
`timescale 1ns/1ps
module iefb_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench control: accept low models a slow core
  input wire logic accept,
  input wire logic ret_cmd,
  // block side
  input wire logic irq_req,
  output logic irq_ack,
  output logic ret_pulse,
  output int taken
);
  logic busy_reg;
  // one take per service, return only while servicing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ack <= 1'b0;
      ret_pulse <= 1'b0;
      busy_reg <= 1'b0;
      taken <= 0;
    end else begin
      irq_ack <= irq_req && accept && !busy_reg && !irq_ack;
      ret_pulse <= ret_cmd && busy_reg && !ret_pulse;
      if (irq_ack) begin
        busy_reg <= 1'b1;
        taken <= taken + 1;
      end else if (ret_pulse) busy_reg <= 1'b0;
    end
  end
endmodule // iefb_core_model

// ===== bench/iefb_irq_bank_sva.sv
`timescale 1ns/1ps
module iefb_irq_bank_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port
  input wire logic [iefb_pkg::ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [iefb_pkg::DATA_W-1:0] RDATA,
  // events and core
  input wire logic TIMER_ROLLOVER,
  input wire logic IRQ_ACK,
  input wire logic RETURN_FROM_IRQ,
  input wire logic IRQ_REQ,
  input wire logic VECTOR_LOAD,
  input wire logic [iefb_pkg::VECTOR_W-1:0] VECTOR_ADDR
);
  import iefb_pkg::*;
  logic rd_core_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // read data shows the state held before the read edge
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) rd_core_reg <= 1'b0;
    else rd_core_reg <= RD && (ADDR == CORE_CTRL_IDX);
  end
  a_vector_fixed: assert property (VECTOR_ADDR == IRQ_VECTOR)
    else $error("vector address wrong");
  a_vector_pulse: assert property (VECTOR_LOAD |=> !VECTOR_LOAD)
    else $error("vector load longer than one cycle");
  a_vector_cause: assert property (VECTOR_LOAD |-> $past(IRQ_ACK) && !IRQ_REQ)
    else $error("vector load without a take");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_read: assert property ($past(RD) && $past(ADDR) > PERIPH_EN_IDX |-> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_timer_sticky: assert property ($past(TIMER_ROLLOVER, 2) && rd_core_reg |-> RDATA[2])
    else $error("timer flag not set");
  a_req_global: assert property (rd_core_reg && !RDATA[7] |-> !IRQ_REQ)
    else $error("request with global enable clear");
  a_req_core: assert property (rd_core_reg && !RDATA[6] && !$past(IRQ_ACK)
    |-> IRQ_REQ == (RDATA[7] && |(RDATA[5:3] & RDATA[2:0])))
    else $error("request differs from masked flags");
  a_return_sets: assert property ($past(RETURN_FROM_IRQ, 2) && !$past(IRQ_ACK, 2)
    && rd_core_reg |-> RDATA[7])
    else $error("return did not set global enable");
endmodule // iefb_irq_bank_sva
bind iefb_irq_bank iefb_irq_bank_sva i_sva (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .RD(RD),
  .RDATA(RDATA), .TIMER_ROLLOVER(TIMER_ROLLOVER), .IRQ_ACK(IRQ_ACK),
  .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .IRQ_REQ(IRQ_REQ), .VECTOR_LOAD(VECTOR_LOAD),
  .VECTOR_ADDR(VECTOR_ADDR));

// ===== bench/tb_interrupt_enable_flag_bank.sv
`timescale 1ns/1ps
module tb_interrupt_enable_flag_bank;
  import iefb_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic wr = 0;
  logic rd = 0;
  logic tro = 0;
  logic ext_pin = 0;
  logic edge_rise = 1;
  logic accept = 0;
  logic ret_cmd = 0;
  logic [ADDR_W-1:0] addr = 0;
  logic [DATA_W-1:0] wdata = 0;
  logic [DATA_W-1:0] periph = 0;
  logic [DATA_W-1:0] rdata;
  logic [5:0] pa = 0;
  logic [7:0] pb = 0;
  logic [13:0] pce = 14'h0001;
  logic irq_req, irq_ack, ret_pulse, vload;
  logic [VECTOR_W-1:0] vaddr;
  int taken;
  int err_total = 0;
  int checked = 0;
  int n;
  iefb_irq_bank i_dut (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TIMER_ROLLOVER(tro), .EXT_PIN(ext_pin), .EXT_EDGE_RISING(edge_rise),
    .PORT_A_PINS(pa), .PORT_B_PINS(pb), .PIN_CHANGE_ENABLE(pce), .PERIPH_FLAGS(periph),
    .IRQ_ACK(irq_ack), .RETURN_FROM_IRQ(ret_pulse), .IRQ_REQ(irq_req), .VECTOR_LOAD(vload),
    .VECTOR_ADDR(vaddr));
  iefb_core_model i_core (.clk(clk), .nrst(nrst), .accept(accept), .ret_cmd(ret_cmd),
    .irq_req(irq_req), .irq_ack(irq_ack), .ret_pulse(ret_pulse), .taken(taken));
  initial begin
    forever #50 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // tasks start just after an edge and end 1 ns after one
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    #1;
  endtask
  task rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1;
    chk(rdata, exp);
  endtask
  task summarize;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    cyc(1);
    rd_reg(CORE_CTRL_IDX, 8'h00);
    rd_reg(PERIPH_EN_IDX, 8'h00);
    rd_reg(4'h5, 8'h00);
    chk(irq_req, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(PERIPH_EN_IDX, 8'h01 << i);
      rd_reg(PERIPH_EN_IDX, 8'h01 << i);
    end
    wr_reg(4'h7, 8'hff);
    rd_reg(PERIPH_EN_IDX, 8'h80);
    $display("test enables done");
    tro <= 1;
    @(posedge clk);
    tro <= 0;
    #1;
    rd_reg(CORE_CTRL_IDX, 8'h04);
    // a rollover in the clearing cycle must win
    tro <= 1;
    wr_reg(CORE_CTRL_IDX, 8'h00);
    tro <= 0;
    rd_reg(CORE_CTRL_IDX, 8'h04);
    wr_reg(CORE_CTRL_IDX, 8'h00);
    rd_reg(CORE_CTRL_IDX, 8'h00);
    // a pin without its change enable must stay silent
    pb <= 8'h01;
    cyc(6);
    rd_reg(CORE_CTRL_IDX, 8'h00);
    pce <= 14'h0040;
    pb <= 8'h00;
    cyc(6);
    rd_reg(CORE_CTRL_IDX, 8'h01);
    pce <= 14'h0001;
    wr_reg(CORE_CTRL_IDX, 8'h00);
    pa <= 6'h01;
    ext_pin <= 1;
    cyc(6);
    rd_reg(CORE_CTRL_IDX, 8'h03);
    wr_reg(CORE_CTRL_IDX, 8'h00);
    edge_rise <= 0;
    ext_pin <= 0;
    cyc(6);
    rd_reg(CORE_CTRL_IDX, 8'h02);
    $display("test flags done");
    for (int k = 0; k < 3; k++) begin
      wr_reg(CORE_CTRL_IDX, 8'h80 | (8'h04 >> k));
      cyc(2);
      chk(irq_req, 0);
      wr_reg(CORE_CTRL_IDX, 8'h80 | (8'h24 >> k));
      cyc(2);
      chk(irq_req, 1);
      wr_reg(CORE_CTRL_IDX, 8'h24 >> k);
      cyc(2);
      chk(irq_req, 0);
      rd_reg(CORE_CTRL_IDX, 8'h24 >> k);
    end
    $display("test masks done");
    wr_reg(PERIPH_EN_IDX, 8'h01);
    periph <= 8'h01;
    wr_reg(CORE_CTRL_IDX, 8'h80);
    cyc(2);
    chk(irq_req, 0);
    wr_reg(CORE_CTRL_IDX, 8'hc0);
    cyc(2);
    chk(irq_req, 1);
    periph <= 8'h02;
    cyc(2);
    chk(irq_req, 0);
    periph <= 8'h01;
    accept <= 1;
    n = 0;
    while (vload !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(vload, 1);
    chk(irq_req, 0);
    chk(vaddr, 13'h0004);
    accept <= 0;
    rd_reg(CORE_CTRL_IDX, 8'h40);
    chk(taken[15:0], 16'h0001);
    ret_cmd <= 1;
    cyc(1);
    ret_cmd <= 0;
    cyc(1);
    rd_reg(CORE_CTRL_IDX, 8'hc0);
    cyc(1);
    chk(irq_req, 1);
    $display("test take and return done");
    summarize();
  end
endmodule // tb_interrupt_enable_flag_bank

// ===== design/iefb_irq_bank.sv
// What this block does
// - global enable gates every interrupt request
// - group enable gates all peripheral sources
// - timer overflow enable masks its flag
// - external pin enable masks its flag
// - port-change enable masks its flag
// - timer flag set on rollover, software clears
// - external flag set on edge, software clears
// - port-change flag set on enabled pin change
// - eight peripheral enables, read/write, reset zero
// - flags set regardless of the core_irq_control enable bits
// - taken request clears global enable, vectors 0004h
// - return sets global enable again
`timescale 1ns/1ps
module iefb_irq_bank #(
  parameter int PORT_A_W = 6,
  parameter int PORT_B_W = 8,
  parameter int PERIPH_W = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // register port
  input wire logic [iefb_pkg::ADDR_W-1:0] ADDR,
  input wire logic [iefb_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [iefb_pkg::DATA_W-1:0] RDATA,
  // event sources
  input wire logic TIMER_ROLLOVER,
  input wire logic EXT_PIN,
  input wire logic EXT_EDGE_RISING,
  input wire logic [PORT_A_W-1:0] PORT_A_PINS,
  input wire logic [PORT_B_W-1:0] PORT_B_PINS,
  input wire logic [PORT_A_W+PORT_B_W-1:0] PIN_CHANGE_ENABLE,
  input wire logic [PERIPH_W-1:0] PERIPH_FLAGS,
  // core sequencer
  input wire logic IRQ_ACK,
  input wire logic RETURN_FROM_IRQ,
  output logic IRQ_REQ,
  output logic VECTOR_LOAD,
  output logic [iefb_pkg::VECTOR_W-1:0] VECTOR_ADDR
);
  import iefb_pkg::*;

  localparam int PINS_W = PORT_A_W + PORT_B_W;

  if (PORT_A_W < 1 || PORT_B_W < 1) begin : g_chk_port
    $error("iefb_irq_bank: port widths must be at least 1");
  end
  if (PERIPH_W != DATA_W) begin : g_chk_periph
    $error("iefb_irq_bank: PERIPH_W must equal the register width");
  end
  // the change detector needs a settled stage behind the metastable one
  if (SYNC_STAGES < 2) begin : g_chk_sync
    $error("iefb_irq_bank: SYNC_STAGES must be at least 2");
  end

  // control and flag state
  logic global_irq_enable_reg;
  logic peripheral_group_enable_reg;
  logic timer_overflow_enable_reg;
  logic ext_pin_irq_enable_reg;
  logic port_change_enable_reg;
  logic timer_overflow_flag_reg;
  logic ext_pin_irq_flag_reg;
  logic port_change_flag_reg;
  logic [DATA_W-1:0] peripheral_irq_enable_one_reg;

  // decoded accesses
  logic wr_core;
  logic wr_periph;
  logic [DATA_W-1:0] core_irq_control;

  // synchronised pins
  logic ext_level;
  logic ext_prev;
  logic ext_primed;
  logic [PINS_W-1:0] port_level;
  logic [PINS_W-1:0] port_prev;
  logic port_primed;

  // hardware events, one cycle each, and the pending and request terms
  logic ext_edge_seen;
  logic port_change_seen;
  logic irq_taken;
  logic core_pending;
  logic periph_pending;
  logic irq_req_next;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    addr_hit = (a == idx);
  endfunction

  assign wr_core = WR && addr_hit(ADDR, CORE_CTRL_IDX);
  assign wr_periph = WR && addr_hit(ADDR, PERIPH_EN_IDX);

  assign core_irq_control = {
    global_irq_enable_reg,
    peripheral_group_enable_reg,
    timer_overflow_enable_reg,
    ext_pin_irq_enable_reg,
    port_change_enable_reg,
    timer_overflow_flag_reg,
    ext_pin_irq_flag_reg,
    port_change_flag_reg
  };

  iefb_pin_sync #(
    .WIDTH(1)
  ) u_ext_sync (
    .CLK(CLK),
    .NRST(NRST),
    .PINS(EXT_PIN),
    .LEVEL(ext_level),
    .PREV(ext_prev),
    .PRIMED(ext_primed)
  );

  iefb_pin_sync #(
    .WIDTH(PINS_W)
  ) u_port_sync (
    .CLK(CLK),
    .NRST(NRST),
    .PINS({PORT_B_PINS, PORT_A_PINS}),
    .LEVEL(port_level),
    .PREV(port_prev),
    .PRIMED(port_primed)
  );

  // edge polarity chosen by the caller; the edge itself is what counts
  assign ext_edge_seen = ext_primed &&
    (EXT_EDGE_RISING ? (ext_level && !ext_prev) : (!ext_level && ext_prev));

  assign port_change_seen = port_primed &&
    (|((port_level ^ port_prev) & PIN_CHANGE_ENABLE));

  // a take only counts while the global enable is set
  assign irq_taken = IRQ_ACK && global_irq_enable_reg;

  // reset clears global enable
  // take beats return beats write, so a take racing software is never lost
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      global_irq_enable_reg <= CORE_CTRL_RST[GLOBAL_EN_BIT];
    end else if (irq_taken) begin
      global_irq_enable_reg <= 1'b0;
    end else if (RETURN_FROM_IRQ) begin
      global_irq_enable_reg <= 1'b1;
    end else if (wr_core) begin
      global_irq_enable_reg <= WDATA[GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      peripheral_group_enable_reg <= CORE_CTRL_RST[PERIPH_GRP_EN_BIT];
    end else if (wr_core) begin
      peripheral_group_enable_reg <= WDATA[PERIPH_GRP_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      timer_overflow_enable_reg <= CORE_CTRL_RST[TIMER_OVF_EN_BIT];
    end else if (wr_core) begin
      timer_overflow_enable_reg <= WDATA[TIMER_OVF_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ext_pin_irq_enable_reg <= CORE_CTRL_RST[EXT_PIN_EN_BIT];
    end else if (wr_core) begin
      ext_pin_irq_enable_reg <= WDATA[EXT_PIN_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_change_enable_reg <= CORE_CTRL_RST[PORT_CHG_EN_BIT];
    end else if (wr_core) begin
      port_change_enable_reg <= WDATA[PORT_CHG_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      timer_overflow_flag_reg <= CORE_CTRL_RST[TIMER_OVF_FLAG_BIT];
    end else if (TIMER_ROLLOVER) begin
      timer_overflow_flag_reg <= 1'b1;
    end else if (wr_core) begin
      timer_overflow_flag_reg <= WDATA[TIMER_OVF_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ext_pin_irq_flag_reg <= CORE_CTRL_RST[EXT_PIN_FLAG_BIT];
    end else if (ext_edge_seen) begin
      ext_pin_irq_flag_reg <= 1'b1;
    end else if (wr_core) begin
      ext_pin_irq_flag_reg <= WDATA[EXT_PIN_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_change_flag_reg <= CORE_CTRL_RST[PORT_CHG_FLAG_BIT];
    end else if (port_change_seen) begin
      port_change_flag_reg <= 1'b1;
    end else if (wr_core) begin
      port_change_flag_reg <= WDATA[PORT_CHG_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      peripheral_irq_enable_one_reg <= PERIPH_EN_RST;
    end else if (wr_periph) begin
      peripheral_irq_enable_one_reg <= WDATA;
    end
  end

  assign core_pending =
    (timer_overflow_enable_reg && timer_overflow_flag_reg) ||
    (ext_pin_irq_enable_reg && ext_pin_irq_flag_reg) ||
    (port_change_enable_reg && port_change_flag_reg);

  assign periph_pending = peripheral_group_enable_reg &&
    (|(PERIPH_FLAGS & peripheral_irq_enable_one_reg));

  // global enable gates all
  // the take cycle is masked so one request is never taken twice
  always_comb begin
    irq_req_next = global_irq_enable_reg && !IRQ_ACK && (core_pending || periph_pending);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ_REQ <= 1'b0;
    end else begin
      IRQ_REQ <= irq_req_next;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      VECTOR_LOAD <= 1'b0;
    end else begin
      VECTOR_LOAD <= irq_taken;
    end
  end

  // fixed vector, held in a flop like every output
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      VECTOR_ADDR <= IRQ_VECTOR;
    end else begin
      VECTOR_ADDR <= IRQ_VECTOR;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= UNMAPPED_RDATA;
    end else if (RD) begin
      unique case (ADDR)
        CORE_CTRL_IDX: RDATA <= core_irq_control;
        PERIPH_EN_IDX: RDATA <= peripheral_irq_enable_one_reg;
        default: RDATA <= UNMAPPED_RDATA;
      endcase
    end else begin
      RDATA <= UNMAPPED_RDATA;
    end
  end
endmodule // iefb_irq_bank

// ===== design/iefb_pin_sync.sv
`timescale 1ns/1ps
module iefb_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // asynchronous pins
  input wire logic [WIDTH-1:0] PINS,
  // synchronised level, level one cycle earlier, history valid
  output logic [WIDTH-1:0] LEVEL,
  output logic [WIDTH-1:0] PREV,
  output logic PRIMED
);
  import iefb_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [SYNC_STAGES:0] fill_reg;

  if (WIDTH < 1) begin : g_chk
    $error("iefb_pin_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      meta_reg <= '0;
      LEVEL <= '0;
      PREV <= '0;
    end else begin
      meta_reg <= PINS;
      LEVEL <= meta_reg;
      PREV <= LEVEL;
    end
  end

  // history is trusted only once real pin samples reached PREV,
  // otherwise the reset zeros would look like a change
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fill_reg <= '0;
    end else begin
      fill_reg <= {fill_reg[SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign PRIMED = fill_reg[SYNC_STAGES];
endmodule // iefb_pin_sync

// ===== design/iefb_pkg.sv
package iefb_pkg;
  // register indices on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CORE_CTRL_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] PERIPH_EN_IDX = 4'h1;
  localparam int DATA_W = 8;

  // core_irq_control field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_GRP_EN_BIT = 6;
  localparam int TIMER_OVF_EN_BIT = 5;
  localparam int EXT_PIN_EN_BIT = 4;
  localparam int PORT_CHG_EN_BIT = 3;
  localparam int TIMER_OVF_FLAG_BIT = 2;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int PORT_CHG_FLAG_BIT = 0;

  // reset values
  localparam logic [DATA_W-1:0] CORE_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] PERIPH_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;

  // interrupt vector handed to the core when a request is taken
  localparam int VECTOR_W = 13;
  localparam logic [VECTOR_W-1:0] IRQ_VECTOR = 13'h0004;

  // depth of the pin synchronisers
  localparam int SYNC_STAGES = 2;
endpackage
